// ===== sim/ssar_xmit_model.sv
module ssar_xmit_model (
   input wire logic CLK,
   input wire logic SEND,
   input wire ssar_pkg::ssar_attr_type NEW_ATTR,
   input wire logic SEND_ID,
   input wire logic [7:0] NEW_ID,
   output ssar_pkg::ssar_attr_type ATTR = '0,
   output logic ATTR_VALID = 1'b0,
   output logic [7:0] BLANK_ID = 8'h00,
   output logic BLANK_ID_VALID = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   import ssar_pkg::*;
   // Lines outside a pulse flip, so a sink must not track them
   always @(posedge CLK) begin
      ATTR_VALID <= SEND;
      ATTR <= SEND ? NEW_ATTR : ~ATTR;
      BLANK_ID_VALID <= SEND_ID;
      BLANK_ID <= SEND_ID ? NEW_ID : ~BLANK_ID;
   end
endmodule

// ===== sim/tb_top.sv
module tb_top import ssar_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic rd;
      logic [31:0] d;
      logic err;
   } ssar_exp_type;
   logic CLK = 0;
   logic RST = 1;
   ssar_apb_req_type req = '0;
   ssar_apb_rsp_type rsp;
   logic send = 0;
   logic send_id = 0;
   logic [7:0] new_id = 8'h00;
   ssar_attr_type new_attr = '0;
   ssar_attr_type attr;
   ssar_attr_type a;
   logic attr_valid;
   logic id_valid;
   logic [7:0] id;
   logic [CFG_ADDR_W-1:0] cfg_addr = '0;
   logic [31:0] cfg_data;
   ssar_exp_type q[$];
   ssar_exp_type e;
   int n_errors = 0;
   int comparisons = 0;
   int seed = 11;
   logic [223:0] r;
   logic [31:0] w;
   logic [11:0] ad;
   logic [7:0] b;

   always #20 CLK = ~CLK;

   ssar_xmit_model i_xmit (.CLK(CLK), .SEND(send), .NEW_ATTR(new_attr),
      .SEND_ID(send_id), .NEW_ID(new_id), .ATTR(attr),
      .ATTR_VALID(attr_valid), .BLANK_ID(id), .BLANK_ID_VALID(id_valid));

   ssar_regs i_dut (.CLK(CLK), .RST(RST), .APB_REQ(req), .APB_RSP(rsp),
      .ATTR_VALID(attr_valid), .ATTR(attr), .BLANK_ID_VALID(id_valid),
      .BLANK_ID(id), .CFG_RD_ADDR(cfg_addr), .CFG_RD_DATA(cfg_data));

   task automatic final_report();
      if (n_errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      comparisons++;
      if (g !== x) begin
         n_errors++;
         $display("wrong value at %0t: got %h exp %h", $time, g, x);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] ad,
         input logic [31:0] wd, input logic [3:0] sb,
         input logic [31:0] ed, input logic ee);
      int n;
      @(posedge CLK);
      req <= '{1'b1, 1'b0, wr, ad, wd, sb};
      q.push_back('{!wr, ed, ee});
      @(posedge CLK);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      if (n >= 20) begin
         n_errors++;
         $display("wrong value at %0t: no ready", $time);
         final_report();
      end
   endtask

   // Link-side window port answers one edge after the address
   task automatic cfg(input logic [6:0] ca, input logic [31:0] x);
      @(posedge CLK);
      cfg_addr <= ca;
      repeat (2) @(posedge CLK);
      chk(cfg_data, x);
   endtask

   function automatic logic [31:0] exp_reg(int i, ssar_attr_type t);
      case (i)
         0: return {16'h0, t.hres};
         1: return {31'h0, t.hspol};
         2: return {17'h0, t.hswidth};
         3: return {16'h0, t.hstart};
         4: return {16'h0, t.htotal};
         5: return {16'h0, t.vactive};
         6: return {31'h0, t.vspol};
         7: return {17'h0, t.vswidth};
         8: return {16'h0, t.vstart};
         9: return {16'h0, t.vtotal};
         10: return {24'h0, t.bpc, t.colorimetry_select, t.dyn_range,
            t.comp_fmt, t.clk_mode};
         11: return {29'h0, t.stereo, t.even_line_count_flag};
         12: return {8'h0, t.m_value};
         default: return {8'h0, t.n_value};
      endcase
   endfunction

   always @(posedge CLK) begin
      if (req.psel && req.penable && rsp.pready === 1'b1) begin
         e = q.pop_front();
         if (e.rd)
            chk(rsp.prdata, e.d);
         chk({31'h0, rsp.pslverr}, {31'h0, e.err});
      end
   end

   initial begin
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      for (int i = 0; i < 15; i++)
         apb(0, 12'h500 + 12'(4 * i), 0, 0, 0, 0);
      for (int k = 0; k < 4; k++) begin
         for (int j = 0; j < 7; j++)
            r[32 * j +: 32] = $random(seed);
         a = r[$bits(ssar_attr_type)-1:0];
         a.comp_fmt = 2'(k);
         @(posedge CLK);
         new_attr <= a;
         send <= 1'b1;
         @(posedge CLK);
         send <= 1'b0;
         // Reads also cover the hold while the lines change
         for (int i = 0; i < 14; i++)
            apb(0, 12'h500 + 12'(4 * i), 0, 0, exp_reg(i, a), 0);
      end
      b = 8'($random(seed));
      @(posedge CLK);
      send_id <= 1'b1;
      new_id <= ~b;
      @(posedge CLK);
      new_id <= b;
      @(posedge CLK);
      send_id <= 1'b0;
      apb(0, 12'h538, 0, 0, {24'h0, b}, 0);
      apb(1, 12'h504, ~exp_reg(1, a), 4'hf, 0, 0);
      apb(0, 12'h504, 0, 0, exp_reg(1, a), 0);
      apb(0, 12'h600, 0, 0, 0, 1);
      apb(0, 12'h502, 0, 0, 0, 1);
      for (int i = 0; i < 4; i++) begin
         ad = ((i < 2) ? 12'he00 : 12'hf00) | ((i % 2) ? 12'h0fc : 12'h000);
         w = $random(seed);
         apb(1, ad, w, 4'hf, 0, 0);
         apb(0, ad, 0, 0, w, 0);
         cfg({ad[8], ad[7:2]}, w);
      end
      w = $random(seed);
      apb(1, 12'he04, w, 4'h6, 0, 0);
      apb(0, 12'he04, 0, 0, w & 32'h00ffff00, 0);
      // Second reset clears attributes, id byte and windows
      @(posedge CLK);
      RST <= 1'b1;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      apb(0, 12'h500, 0, 0, 0, 0);
      apb(0, 12'h538, 0, 0, 0, 0);
      apb(0, 12'he04, 0, 0, 0, 0);
      cfg(7'h40, 0);
      final_report();
   end
endmodule

// ===== verilog/ssar_pkg.sv
package ssar_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned WIN_WORDS = 64;
   localparam int unsigned WIN_IDX_W = 6;
   localparam int unsigned CFG_ADDR_W = 7;

   localparam logic [11:0] OFF_HRES = 12'h500;
   localparam logic [11:0] OFF_HSPOL = 12'h504;
   localparam logic [11:0] OFF_HSWIDTH = 12'h508;
   localparam logic [11:0] OFF_HSTART = 12'h50c;
   localparam logic [11:0] OFF_HTOTAL = 12'h510;
   localparam logic [11:0] OFF_VACTIVE = 12'h514;
   localparam logic [11:0] OFF_VSPOL = 12'h518;
   localparam logic [11:0] OFF_VSWIDTH = 12'h51c;
   localparam logic [11:0] OFF_VSTART = 12'h520;
   localparam logic [11:0] OFF_VTOTAL = 12'h524;
   localparam logic [11:0] OFF_FMT1 = 12'h528;
   localparam logic [11:0] OFF_FMT2 = 12'h52c;
   localparam logic [11:0] OFF_CLK_M = 12'h530;
   localparam logic [11:0] OFF_CLK_N = 12'h534;
   localparam logic [11:0] OFF_BLANK_ID = 12'h538;
   localparam logic [11:0] OFF_SRC_WIN = 12'he00;
   localparam logic [11:0] OFF_SNK_WIN = 12'hf00;
   // Both windows share these upper address bits
   localparam logic [2:0] WIN_TOP = 3'h7;

   // First format register layout
   localparam int unsigned BPC_POS = 5;
   localparam int unsigned COLOR_POS = 4;
   localparam int unsigned RANGE_POS = 3;
   localparam int unsigned CFMT_POS = 1;
   localparam int unsigned CLKMODE_POS = 0;
   // Second format register layout
   localparam int unsigned STEREO_POS = 1;
   localparam int unsigned EVEN_POS = 0;

   localparam logic [31:0] RD_ZERO = 32'h0;

   typedef struct packed {
      logic [15:0] hres;
      logic hspol;
      logic [14:0] hswidth;
      logic [15:0] hstart;
      logic [15:0] htotal;
      logic [15:0] vactive;
      logic vspol;
      logic [14:0] vswidth;
      logic [15:0] vstart;
      logic [15:0] vtotal;
      logic [2:0] bpc;
      logic colorimetry_select;
      logic dyn_range;
      logic [1:0] comp_fmt;
      logic clk_mode;
      logic [1:0] stereo;
      logic even_line_count_flag;
      logic [23:0] m_value;
      logic [23:0] n_value;
   } ssar_attr_type;

   localparam ssar_attr_type ATTR_RESET = '0;
   localparam logic [7:0] BLANK_ID_RESET = 8'h00;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } ssar_apb_req_type;

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } ssar_apb_rsp_type;
endpackage

// ===== verilog/ssar_regs.sv
// Summary of operation
// - Report horizontal active pixels, 16 bits
// - Horizontal sync polarity in bit 0
// - Horizontal sync width, 15 bits
// - Sync leading edge to active data, 16 bits
// - Total clocks per line, 16 bits
// - Active lines per frame, 16 bits
// - Vertical sync polarity in bit 0
// - Vertical sync width in lines, 15 bits
// - Vertical sync to first active line
// - Total lines per frame, 16 bits
// - Depth, colorimetry, range in first format register
// - Component format and clock mode bits
// - Second format: zeros, stereo, even flag
// - Expose 24-bit clock recovery M value
// - Expose 24-bit clock recovery N value
// - Hold latest blanking id byte
// - Read-write source-specific window
// - Read-write sink-specific window
//
// Register access over APB is this design's own decision.
module ssar_regs (
   input wire logic CLK,
   input wire logic RST,
   input wire ssar_pkg::ssar_apb_req_type APB_REQ,
   output ssar_pkg::ssar_apb_rsp_type APB_RSP,
   input wire logic ATTR_VALID,
   input wire ssar_pkg::ssar_attr_type ATTR,
   input wire logic BLANK_ID_VALID,
   input wire logic [7:0] BLANK_ID,
   input wire logic [ssar_pkg::CFG_ADDR_W-1:0] CFG_RD_ADDR,
   output logic [31:0] CFG_RD_DATA
);
   import ssar_pkg::*;

   typedef struct packed {
      ssar_attr_type attr;
      logic [7:0] blank_id;
      logic [WIN_WORDS-1:0][31:0] src_win;
      logic [WIN_WORDS-1:0][31:0] snk_win;
      logic [31:0] prdata;
      logic pslverr;
      logic [31:0] cfg_rd_data;
   } ssar_state_type;

   ssar_state_type st_r;
   ssar_state_type st_nxt;

   logic setup_ph;
   logic access_ph;
   logic in_win;
   logic win_snk;
   logic [WIN_IDX_W-1:0] win_idx;
   logic [31:0] rd_word;
   logic rd_err;
   logic [31:0] wmask;

   assign setup_ph = APB_REQ.psel && !APB_REQ.penable;
   assign access_ph = APB_REQ.psel && APB_REQ.penable;
   assign in_win = APB_REQ.paddr[11:9] == WIN_TOP;
   assign win_snk = APB_REQ.paddr[8];
   assign win_idx = APB_REQ.paddr[7:2];

   // Byte lane mask from the write strobes
   genvar gb;
   generate
      for (gb = 0; gb < 4; gb++) begin : g_lane
         assign wmask[gb*8 +: 8] = {8{APB_REQ.pstrb[gb]}};
      end
   endgenerate

   // Read decode, sampled in the setup phase
   always_comb begin
      rd_word = RD_ZERO;
      rd_err = 1'b0;
      if (APB_REQ.paddr[1:0] != 2'b00) begin
         rd_err = 1'b1;
      end else if (in_win) begin
         if (win_snk) begin
            rd_word = st_r.snk_win[win_idx];
         end else begin
            rd_word = st_r.src_win[win_idx];
         end
      end else begin
         case (APB_REQ.paddr)
            OFF_HRES: rd_word[15:0] = st_r.attr.hres;
            OFF_HSPOL: rd_word[0] = st_r.attr.hspol;
            OFF_HSWIDTH: rd_word[14:0] = st_r.attr.hswidth;
            OFF_HSTART: rd_word[15:0] = st_r.attr.hstart;
            OFF_HTOTAL: rd_word[15:0] = st_r.attr.htotal;
            OFF_VACTIVE: rd_word[15:0] = st_r.attr.vactive;
            OFF_VSPOL: rd_word[0] = st_r.attr.vspol;
            OFF_VSWIDTH: rd_word[14:0] = st_r.attr.vswidth;
            OFF_VSTART: rd_word[15:0] = st_r.attr.vstart;
            OFF_VTOTAL: rd_word[15:0] = st_r.attr.vtotal;
            OFF_FMT1: begin
               rd_word[BPC_POS +: 3] = st_r.attr.bpc;
               rd_word[COLOR_POS] = st_r.attr.colorimetry_select;
               rd_word[RANGE_POS] = st_r.attr.dyn_range;
               rd_word[CFMT_POS +: 2] = st_r.attr.comp_fmt;
               rd_word[CLKMODE_POS] = st_r.attr.clk_mode;
            end
            OFF_FMT2: begin
               // Upper bits stay zero
               rd_word[STEREO_POS +: 2] = st_r.attr.stereo;
               rd_word[EVEN_POS] = st_r.attr.even_line_count_flag;
            end
            OFF_CLK_M: rd_word[23:0] = st_r.attr.m_value;
            OFF_CLK_N: rd_word[23:0] = st_r.attr.n_value;
            OFF_BLANK_ID: rd_word[7:0] = st_r.blank_id;
            default: rd_err = 1'b1;
         endcase
      end
   end

   always_comb begin
      st_nxt = st_r;
      // New attribute set replaces the old one whole
      if (ATTR_VALID) begin
         st_nxt.attr = ATTR;
      end
      if (BLANK_ID_VALID) begin
         st_nxt.blank_id = BLANK_ID;
      end
      if (setup_ph) begin
         st_nxt.prdata = APB_REQ.pwrite ? RD_ZERO : rd_word;
         st_nxt.pslverr = rd_err;
      end
      // Writes land at the access edge; attribute space ignores them
      if (access_ph && APB_REQ.pwrite && !st_r.pslverr && in_win) begin
         if (win_snk) begin
            st_nxt.snk_win[win_idx] = (st_r.snk_win[win_idx] & ~wmask)
               | (APB_REQ.pwdata & wmask);
         end else begin
            st_nxt.src_win[win_idx] = (st_r.src_win[win_idx] & ~wmask)
               | (APB_REQ.pwdata & wmask);
         end
      end
      // Link side reads the windows; top address bit picks sink
      if (CFG_RD_ADDR[CFG_ADDR_W-1]) begin
         st_nxt.cfg_rd_data = st_r.snk_win[CFG_RD_ADDR[WIN_IDX_W-1:0]];
      end else begin
         st_nxt.cfg_rd_data = st_r.src_win[CFG_RD_ADDR[WIN_IDX_W-1:0]];
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Zero wait states; data was captured during setup
   assign APB_RSP = '{pready: access_ph, prdata: st_r.prdata,
      pslverr: access_ph && st_r.pslverr};
   assign CFG_RD_DATA = st_r.cfg_rd_data;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   sequence s_rd(logic [11:0] off);
      APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite
         && APB_REQ.paddr == off;
   endsequence

   sequence s_acc;
      APB_REQ.psel && APB_REQ.penable;
   endsequence

   property p_attr_load;
      ATTR_VALID |=> st_r.attr == $past(ATTR);
   endproperty
   a_attr_load: assert property (p_attr_load)
      else $error("attribute set not captured");

   property p_attr_hold;
      !ATTR_VALID |=> $stable(st_r.attr);
   endproperty
   a_attr_hold: assert property (p_attr_hold)
      else $error("attribute changed without new set");

   property p_hres_rd;
      s_rd(OFF_HRES) ##1 s_acc
         |-> APB_RSP.prdata == {16'h0, $past(st_r.attr.hres)};
   endproperty
   a_hres_rd: assert property (p_hres_rd)
      else $error("horizontal resolution read wrong");

   property p_hspol_rd;
      s_rd(OFF_HSPOL) ##1 s_acc
         |-> APB_RSP.prdata == {31'h0, $past(st_r.attr.hspol)};
   endproperty
   a_hspol_rd: assert property (p_hspol_rd)
      else $error("horizontal polarity read wrong");

   property p_hswidth_rd;
      s_rd(OFF_HSWIDTH) ##1 s_acc
         |-> APB_RSP.prdata == {17'h0, $past(st_r.attr.hswidth)};
   endproperty
   a_hswidth_rd: assert property (p_hswidth_rd)
      else $error("horizontal sync width read wrong");

   property p_vspol_rd;
      s_rd(OFF_VSPOL) ##1 s_acc
         |-> APB_RSP.prdata == {31'h0, $past(st_r.attr.vspol)};
   endproperty
   a_vspol_rd: assert property (p_vspol_rd)
      else $error("vertical polarity read wrong");

   property p_fmt2_rd;
      s_rd(OFF_FMT2) ##1 s_acc |-> APB_RSP.prdata[31:3] == 29'h0
         && APB_RSP.prdata[0] == $past(st_r.attr.even_line_count_flag);
   endproperty
   a_fmt2_rd: assert property (p_fmt2_rd)
      else $error("second format register read wrong");

   property p_m_rd;
      s_rd(OFF_CLK_M) ##1 s_acc
         |-> APB_RSP.prdata == {8'h0, $past(st_r.attr.m_value)};
   endproperty
   a_m_rd: assert property (p_m_rd)
      else $error("M value read wrong");

   property p_n_rd;
      s_rd(OFF_CLK_N) ##1 s_acc
         |-> APB_RSP.prdata == {8'h0, $past(st_r.attr.n_value)};
   endproperty
   a_n_rd: assert property (p_n_rd)
      else $error("N value read wrong");

   property p_blank_id;
      BLANK_ID_VALID ##1 (s_rd(OFF_BLANK_ID) and !BLANK_ID_VALID)
         ##1 s_acc |-> APB_RSP.prdata == {24'h0, $past(BLANK_ID, 2)};
   endproperty
   a_blank_id: assert property (p_blank_id)
      else $error("blank id byte not held");

   property p_src_wr;
      s_acc and (APB_REQ.pwrite && APB_REQ.paddr == OFF_SRC_WIN
         && APB_REQ.pstrb == 4'hf && !APB_RSP.pslverr)
         |=> st_r.src_win[0] == $past(APB_REQ.pwdata);
   endproperty
   a_src_wr: assert property (p_src_wr)
      else $error("source window write lost");

   property p_snk_wr;
      s_acc and (APB_REQ.pwrite && APB_REQ.paddr == OFF_SNK_WIN
         && APB_REQ.pstrb == 4'hf && !APB_RSP.pslverr)
         |=> st_r.snk_win[0] == $past(APB_REQ.pwdata);
   endproperty
   a_snk_wr: assert property (p_snk_wr)
      else $error("sink window write lost");

   property p_hstart_rd;
      s_rd(OFF_HSTART) ##1 s_acc
         |-> APB_RSP.prdata == {16'h0, $past(st_r.attr.hstart)};
   endproperty
   a_hstart_rd: assert property (p_hstart_rd)
      else $error("horizontal start read wrong");

   property p_htotal_rd;
      s_rd(OFF_HTOTAL) ##1 s_acc
         |-> APB_RSP.prdata == {16'h0, $past(st_r.attr.htotal)};
   endproperty
   a_htotal_rd: assert property (p_htotal_rd)
      else $error("line total read wrong");

   property p_vactive_rd;
      s_rd(OFF_VACTIVE) ##1 s_acc
         |-> APB_RSP.prdata == {16'h0, $past(st_r.attr.vactive)};
   endproperty
   a_vactive_rd: assert property (p_vactive_rd)
      else $error("active line count read wrong");

   property p_vswidth_rd;
      s_rd(OFF_VSWIDTH) ##1 s_acc
         |-> APB_RSP.prdata == {17'h0, $past(st_r.attr.vswidth)};
   endproperty
   a_vswidth_rd: assert property (p_vswidth_rd)
      else $error("vertical sync width read wrong");

   property p_vstart_rd;
      s_rd(OFF_VSTART) ##1 s_acc
         |-> APB_RSP.prdata == {16'h0, $past(st_r.attr.vstart)};
   endproperty
   a_vstart_rd: assert property (p_vstart_rd)
      else $error("vertical start read wrong");

   property p_vtotal_rd;
      s_rd(OFF_VTOTAL) ##1 s_acc
         |-> APB_RSP.prdata == {16'h0, $past(st_r.attr.vtotal)};
   endproperty
   a_vtotal_rd: assert property (p_vtotal_rd)
      else $error("frame total read wrong");

   property p_fmt1_depth_rd;
      s_rd(OFF_FMT1) ##1 s_acc
         |-> APB_RSP.prdata[BPC_POS +: 3] == $past(st_r.attr.bpc)
         && APB_RSP.prdata[COLOR_POS] == $past(st_r.attr.colorimetry_select)
         && APB_RSP.prdata[RANGE_POS] == $past(st_r.attr.dyn_range);
   endproperty
   a_fmt1_depth_rd: assert property (p_fmt1_depth_rd)
      else $error("depth, colorimetry or range read wrong");

   property p_fmt1_mode_rd;
      s_rd(OFF_FMT1) ##1 s_acc |-> APB_RSP.prdata[31:8] == 24'h0
         && APB_RSP.prdata[CFMT_POS +: 2] == $past(st_r.attr.comp_fmt)
         && APB_RSP.prdata[CLKMODE_POS] == $past(st_r.attr.clk_mode);
   endproperty
   a_fmt1_mode_rd: assert property (p_fmt1_mode_rd)
      else $error("component format or clock mode read wrong");

   property p_stereo_rd;
      s_rd(OFF_FMT2) ##1 s_acc
         |-> APB_RSP.prdata[STEREO_POS +: 2] == $past(st_r.attr.stereo);
   endproperty
   a_stereo_rd: assert property (p_stereo_rd)
      else $error("stereo field read wrong");

   property p_blank_load;
      BLANK_ID_VALID |=> st_r.blank_id == $past(BLANK_ID);
   endproperty
   a_blank_load: assert property (p_blank_load)
      else $error("blank id byte not loaded");

   property p_blank_keep;
      !BLANK_ID_VALID |=> $stable(st_r.blank_id);
   endproperty
   a_blank_keep: assert property (p_blank_keep)
      else $error("blank id byte changed without new byte");

   property p_src_rd;
      s_rd(OFF_SRC_WIN) ##1 s_acc
         |-> APB_RSP.prdata == $past(st_r.src_win[0]);
   endproperty
   a_src_rd: assert property (p_src_rd)
      else $error("source window read wrong");

   property p_snk_rd;
      s_rd(OFF_SNK_WIN) ##1 s_acc
         |-> APB_RSP.prdata == $past(st_r.snk_win[0]);
   endproperty
   a_snk_rd: assert property (p_snk_rd)
      else $error("sink window read wrong");

   property p_src_keep;
      !(access_ph && APB_REQ.pwrite) |=> $stable(st_r.src_win);
   endproperty
   a_src_keep: assert property (p_src_keep)
      else $error("source window changed without write");

   property p_snk_keep;
      !(access_ph && APB_REQ.pwrite) |=> $stable(st_r.snk_win);
   endproperty
   a_snk_keep: assert property (p_snk_keep)
      else $error("sink window changed without write");

   property p_cfg_src_rd;
      !CFG_RD_ADDR[CFG_ADDR_W-1] |=> CFG_RD_DATA
         == $past(st_r.src_win[CFG_RD_ADDR[WIN_IDX_W-1:0]]);
   endproperty
   a_cfg_src_rd: assert property (p_cfg_src_rd)
      else $error("link side source window read wrong");

   property p_cfg_snk_rd;
      CFG_RD_ADDR[CFG_ADDR_W-1] |=> CFG_RD_DATA
         == $past(st_r.snk_win[CFG_RD_ADDR[WIN_IDX_W-1:0]]);
   endproperty
   a_cfg_snk_rd: assert property (p_cfg_snk_rd)
      else $error("link side sink window read wrong");

   property p_src_strb_wr;
      s_acc and (APB_REQ.pwrite && APB_REQ.paddr == OFF_SRC_WIN + 12'h4
         && APB_REQ.pstrb == 4'h6 && !APB_RSP.pslverr)
         |=> st_r.src_win[1][31:24] == $past(st_r.src_win[1][31:24])
         && st_r.src_win[1][7:0] == $past(st_r.src_win[1][7:0]);
   endproperty
   a_src_strb_wr: assert property (p_src_strb_wr)
      else $error("unselected window bytes changed");
endmodule
